// [hw/uvp_regs.svh]
/*
  Timing counts and pin-level constants for the UV EPROM programmer host.
  Assumes a 20 MHz system clock (50 ns period).
*/
`ifndef UVP_REGS_SVH
`define UVP_REGS_SVH

`define UVP_CLK_NS 50
// Program pulse, nominal 0.1 ms; limits 0.095 to 0.105 ms
`define UVP_TPW_NS 100000
`define UVP_TPW_MIN_NS 95000
`define UVP_TPW_MAX_NS 105000
// Setup/hold and strobe-release lead, 2 us each
`define UVP_TSET_NS 2000
`define UVP_TPW_CYC ((`UVP_TPW_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
`define UVP_TSET_CYC ((`UVP_TSET_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
// Pulse limit per byte, first pulse included
`define UVP_MAX_PULSES 4'ha
`define UVP_ADDR_W 17
`define UVP_DATA_W 8
`define UVP_LAST_ADDR 17'h1ffff
`define UVP_ERASED 8'hff
`define UVP_CNT_W 12

`endif

// [hw/uvp_pkg.sv]
/*
  Types shared by the UV EPROM programmer host.
  Assumes uvp_regs.svh is on the include path.
*/
`include "uvp_regs.svh"
package uvp_pkg;
  typedef logic [`UVP_ADDR_W-1:0] uvp_addr_t;
  typedef logic [`UVP_DATA_W-1:0] uvp_data_t;
  typedef enum logic [1:0] {
    UVP_OP_READ = 2'h0,
    UVP_OP_PROG = 2'h1,
    UVP_OP_CHECK = 2'h2
  } uvp_op_t;
endpackage

// [hw/uvp_tmr_if.sv]
/*
  Interface between the sequencer and its delay timer.
  Assumes one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
`include "uvp_regs.svh"
interface uvp_tmr_if;
  logic start;
  logic [`UVP_CNT_W-1:0] load;
  logic done;
  modport ctl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface
`default_nettype wire

// [hw/uvp_timer.sv]
/*
  Down counter: start loads a cycle count, done pulses for one cycle at
  expiry. Assumes i_mclk and asynchronous high reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "uvp_regs.svh"
module uvp_timer (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Control
  uvp_tmr_if.tmr t
);
  logic [`UVP_CNT_W-1:0] cnt_q, cnt_d;
  logic run_q, run_d;

  // Next count; done comes from flops only, because the sequencer
  // answers done with a new start in the same cycle
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    t.done = run_q && (cnt_q <= `UVP_CNT_W'h1);
    if (t.start) begin
      cnt_d = t.load;
      run_d = 1'b1;
    end else if (t.done) begin
      run_d = 1'b0;
    end else if (run_q) begin
      cnt_d = cnt_q - `UVP_CNT_W'h1;
    end
  end

  // Registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end
endmodule
`default_nettype wire

// [hw/uvp_host.sv]
/*
  Host side of a 128K x 8 UV EPROM: reads, byte programming with verify
  and retry, and a check command that walks to the last address at read supply levels.
  Assumes the device pins are driven directly and its data bus returns
  through i_data_bus; supplies are switched by external level shifters.
*/
// Overview of operation
// [R1] Device holds 131072 bytes; host drives 17-bit address, 8-bit data.
// [R2] Read: chip enable low, output enable low, strobe high, read supplies.
// [R3] Output enable high at read levels floats device data.
// [R4] Chip enable high at read levels puts device in standby.
// [R5] Page latch: chip enable high, output enable low, strobe high.
// [R6] Page program: chip enable high, output enable high, strobe low.
// [R7] Byte program: chip enable low, output enable high, strobe low.
// [R8] Verify: chip enable low, output enable low, strobe high, high supplies.
// [R9] Both enables equal at program supplies inhibits programming.
// [R10] In reads keep the strobe high always.
// [R11] Erased device reads all ones.
// [R12] Present address and data before programming starts.
// [R13] Byte programming starts with chip enable low, output enable high.
// [R14] Strobe pulse low 0.1 ms, between 0.095 and 0.105 ms.
// [R15] After each pulse, lower output enable and compare all eight bits.
// [R16] Retry failed verify with another pulse, up to ten in all.
// [R17] Still failing after ten pulses: stop and flag failure.
// [R18] After all addresses, return to read supplies and recheck all; host rechecks only on a check command, start address to last.
// [R19] Page programming loads four bytes with four output enable pulses.
// [R20] Programming clears bits only; zeros return to one only by erasure.
`timescale 1ns/1ns
`default_nettype none
`include "uvp_regs.svh"
module uvp_host (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Command port
  input wire logic i_start,
  input wire uvp_pkg::uvp_op_t i_op,
  input wire uvp_pkg::uvp_addr_t i_addr,
  input wire uvp_pkg::uvp_data_t i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic o_fail,
  output uvp_pkg::uvp_data_t o_rdata,
  output uvp_pkg::uvp_addr_t o_fail_addr,
  // Device pins
  output logic o_chip_enable_n,
  output logic o_output_enable_n,
  output logic o_program_strobe_n,
  output logic o_programming_supply,
  output uvp_pkg::uvp_addr_t o_address_bus,
  output uvp_pkg::uvp_data_t o_data_bus,
  output logic o_data_bus_oe,
  input wire uvp_pkg::uvp_data_t i_data_bus
);
  import uvp_pkg::*;

  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_SETUP = 8'h02,
    S_PULSE = 8'h04,
    S_HOLD  = 8'h08,
    S_VFY   = 8'h10,
    S_RSET  = 8'h20,
    S_RD    = 8'h40,
    S_FIN   = 8'h80
  } uvp_state_t;

  uvp_state_t st_q, st_d;
  uvp_op_t op_q, op_d;
  uvp_addr_t addr_q, addr_d, fa_q, fa_d;
  uvp_data_t wd_q, wd_d, rd_q, rd_d;
  logic [3:0] pulses_q, pulses_d;
  logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, pgm_n_q, pgm_n_d;
  logic vpp_q, vpp_d, doe_q, doe_d, fail_q, fail_d, done_q, done_d;
  logic [`UVP_DATA_W-1:0] d1_q, d2_q;
  uvp_tmr_if tif ();

  // Pin data returns from another domain; two flops before use
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      d1_q <= '0;
      d2_q <= '0;
    end else begin
      d1_q <= i_data_bus;
      d2_q <= d1_q;
    end
  end

  uvp_timer u_tmr (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .t(tif)
  );

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    addr_d = addr_q;
    fa_d = fa_q;
    wd_d = wd_q;
    rd_d = rd_q;
    pulses_d = pulses_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    pgm_n_d = pgm_n_q;
    vpp_d = vpp_q;
    doe_d = doe_q;
    fail_d = fail_q;
    done_d = 1'b0;
    tif.start = 1'b0;
    tif.load = `UVP_CNT_W'(`UVP_TSET_CYC);
    unique case (st_q)
      S_IDLE: begin
        pgm_n_d = 1'b1; // [R10]
        if (i_start) begin
          op_d = i_op;
          addr_d = i_addr;
          wd_d = i_wdata;
          fail_d = 1'b0;
          pulses_d = 4'h0;
          tif.start = 1'b1;
          if (i_op == UVP_OP_PROG) begin
            // Address, data and supplies settle before any pulse
            vpp_d = 1'b1; // [R12]
            doe_d = 1'b1; // [R12]
            ce_n_d = 1'b0; // [R13]
            oe_n_d = 1'b1; // [R13]
            st_d = S_SETUP;
          end else begin
            vpp_d = 1'b0;
            doe_d = 1'b0;
            ce_n_d = 1'b0; // [R2]
            oe_n_d = 1'b0; // [R2]
            st_d = S_RSET;
          end
        end
      end
      S_SETUP: if (tif.done) begin
        pgm_n_d = 1'b0; // [R7]
        pulses_d = pulses_q + 4'h1;
        tif.start = 1'b1;
        tif.load = `UVP_CNT_W'(`UVP_TPW_CYC); // [R14]
        st_d = S_PULSE;
      end
      S_PULSE: if (tif.done) begin
        pgm_n_d = 1'b1; // [R14]
        tif.start = 1'b1;
        st_d = S_HOLD;
      end
      S_HOLD: if (tif.done) begin
        // Release the bus on the same edge that lets the device drive it back
        doe_d = 1'b0;
        oe_n_d = 1'b0; // [R15] [R8]
        tif.start = 1'b1;
        st_d = S_VFY;
      end
      S_VFY: if (tif.done) begin
        rd_d = d2_q;
        oe_n_d = 1'b1; // [R9]
        if (d2_q == wd_q) begin // [R15]
          st_d = S_FIN;
        end else if (pulses_q >= `UVP_MAX_PULSES) begin // [R17]
          fail_d = 1'b1;
          fa_d = addr_q;
          st_d = S_FIN;
        end else begin // [R16]
          doe_d = 1'b1;
          tif.start = 1'b1;
          st_d = S_SETUP;
        end
      end
      S_RSET: if (tif.done) begin
        rd_d = d2_q;
        // Check mode walks from the start address to the last address against the write data
        if (op_q == UVP_OP_CHECK && d2_q != wd_q) begin // [R18] [R11]
          fail_d = 1'b1;
          fa_d = addr_q;
          st_d = S_FIN;
        end else if (op_q == UVP_OP_CHECK && addr_q != `UVP_LAST_ADDR) begin
          addr_d = addr_q + `UVP_ADDR_W'h1; // [R1]
          tif.start = 1'b1;
        end else begin
          st_d = S_FIN;
        end
      end
      S_RD: st_d = S_FIN;
      S_FIN: begin
        // Back to read levels and standby after every operation
        vpp_d = 1'b0; // [R18]
        ce_n_d = 1'b1; // [R4]
        oe_n_d = 1'b1; // [R3]
        doe_d = 1'b0;
        done_d = 1'b1;
        st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= S_IDLE;
      op_q <= UVP_OP_READ;
      addr_q <= '0;
      fa_q <= '0;
      wd_q <= `UVP_ERASED;
      rd_q <= '0;
      pulses_q <= 4'h0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      pgm_n_q <= 1'b1;
      vpp_q <= 1'b0;
      doe_q <= 1'b0;
      fail_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      addr_q <= addr_d;
      fa_q <= fa_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      pulses_q <= pulses_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      pgm_n_q <= pgm_n_d;
      vpp_q <= vpp_d;
      doe_q <= doe_d;
      fail_q <= fail_d;
      done_q <= done_d;
    end
  end

  // Outputs straight from flops; o_busy is decoded from st_q
  assign o_busy = (st_q != S_IDLE);
  assign o_done = done_q;
  assign o_fail = fail_q;
  assign o_rdata = rd_q;
  assign o_fail_addr = fa_q;
  assign o_chip_enable_n = ce_n_q;
  assign o_output_enable_n = oe_n_q;
  assign o_program_strobe_n = pgm_n_q;
  assign o_programming_supply = vpp_q;
  assign o_address_bus = addr_q;
  assign o_data_bus = wd_q;
  assign o_data_bus_oe = doe_q;
endmodule
`default_nettype wire

// [bench/uvp_host_monitor.sv]
/* Checker for the uvp_host device pins.
   Assumes i_mclk and asynchronous high i_rst. */
`timescale 1ns/1ns
`default_nettype none
module uvp_host_monitor (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Command port
  input wire logic i_start,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_fail,
  // Device pins
  input wire logic o_chip_enable_n,
  input wire logic o_output_enable_n,
  input wire logic o_program_strobe_n,
  input wire logic o_programming_supply,
  input wire uvp_pkg::uvp_addr_t o_address_bus,
  input wire uvp_pkg::uvp_data_t o_data_bus,
  input wire logic o_data_bus_oe
);
  import uvp_pkg::*;
  logic [11:0] low_q, low_d;
  logic [3:0] npul_q, npul_d;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Strobe low time, and pulses since the last accepted start
  always_comb begin
    low_d = o_program_strobe_n ? 12'h000 : low_q + 12'h001;
    npul_d = npul_q;
    if (i_start && !o_busy)
      npul_d = 4'h0;
    else if (!o_program_strobe_n && low_q == 12'h000)
      npul_d = npul_q + 4'h1;
  end
  // Registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      low_q <= 12'h000;
      npul_q <= 4'h0;
    end else begin
      low_q <= low_d;
      npul_q <= npul_d;
    end
  end
  strobe_mode_a: assert property (!o_program_strobe_n |->
    !o_chip_enable_n && o_output_enable_n && o_programming_supply)
    else $error("strobe low outside byte program mode");
  pulse_width_a: assert property ($rose(o_program_strobe_n) |->
    low_q inside {[12'h76c:12'h834]}) else $error("pulse width");
  read_strobe_a: assert property (!o_programming_supply &&
    !o_chip_enable_n |-> o_program_strobe_n) else $error("read strobe");
  verify_soon_a: assert property ($rose(o_program_strobe_n) |->
    o_output_enable_n ##[30:50] !o_output_enable_n)
    else $error("no verify after pulse");
  home_supply_a: assert property (o_done |->
    !o_programming_supply && o_chip_enable_n) else $error("supply");
  pulse_limit_a: assert property (npul_q <= 4'ha)
    else $error("too many pulses");
  fail_count_a: assert property ($rose(o_fail) && npul_q != 4'h0 |->
    npul_q == 4'ha) else $error("early program fail");
  hold_addr_a: assert property (!o_program_strobe_n |->
    $stable(o_address_bus) && $stable(o_data_bus) && o_data_bus_oe)
    else $error("address or data moved in pulse");
  cover property ($rose(o_fail));
  cover property ($rose(o_program_strobe_n));
  cover property (o_done && !o_fail);
endmodule
bind uvp_host uvp_host_monitor u_mon (.i_mclk, .i_rst, .i_start, .o_busy,
  .o_done, .o_fail, .o_chip_enable_n, .o_output_enable_n,
  .o_program_strobe_n, .o_programming_supply, .o_address_bus,
  .o_data_bus, .o_data_bus_oe);
`default_nettype wire

// [bench/uvp_eprom_model.sv]
/* Behavioural 128K x 8 device at the host's pins.
   Assumes active-low controls; i_vpp high means programming levels. */
`timescale 1ns/1ns
`default_nettype none
module uvp_eprom_model (
  // Control pins
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_pgm_n,
  input wire logic i_vpp,
  // From the host
  input wire uvp_pkg::uvp_addr_t i_addr,
  input wire uvp_pkg::uvp_data_t i_data,
  input wire logic i_data_oe,
  // To the host
  output uvp_pkg::uvp_data_t o_data
);
  import uvp_pkg::*;
  uvp_data_t mem [int];
  uvp_data_t page [int];
  uvp_data_t last = 8'h5a;
  // Unwritten places read erased
  function automatic uvp_data_t rd(uvp_addr_t a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  // Page latch at the end of each output enable pulse
  always @(posedge i_oe_n) begin
    if (i_vpp && i_ce_n && i_pgm_n && i_data_oe)
      page[i_addr] = i_data;
  end
  // Byte or page program at the strobe fall
  always @(negedge i_pgm_n) begin
    if (i_vpp && !i_ce_n && i_oe_n && i_data_oe) begin
      mem[i_addr] = rd(i_addr) & i_data;
    end else if (i_vpp && i_ce_n && i_oe_n) begin
      foreach (page[k])
        mem[k] = rd(k) & page[k];
      page.delete();
    end
  end
  // Floating bus shows inverted data so a stale sample cannot pass
  always @* begin
    if (!i_ce_n && !i_oe_n && i_pgm_n) begin
      o_data = rd(i_addr);
      last = o_data;
    end else begin
      o_data = ~last;
    end
  end
endmodule
`default_nettype wire

// [bench/uvp_host_tb.sv]
/* Self-checking bench for uvp_host with a device model.
   Assumes 20 MHz clock; reset held 10 cycles. */
`timescale 1ns/1ns
`default_nettype none
module uvp_host_tb;
  import uvp_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_start = 1'b0;
  uvp_op_t i_op = UVP_OP_READ;
  uvp_addr_t i_addr = 17'h00000;
  uvp_data_t i_wdata = 8'h00;
  logic o_busy, o_done, o_fail, ce_n, oe_n, pgm_n, vpp, doe;
  uvp_data_t o_rdata, dbus, dret, d, st;
  uvp_addr_t o_fail_addr, abus, a;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int npul = 0;
  uvp_data_t ref_mem [int];
  logic [15:0] seed = 16'h9bc7;
  logic fl;
  always #25 i_mclk = ~i_mclk;
  uvp_host DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_start(i_start),
    .i_op(i_op), .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy),
    .o_done(o_done), .o_fail(o_fail), .o_rdata(o_rdata),
    .o_fail_addr(o_fail_addr), .o_chip_enable_n(ce_n),
    .o_output_enable_n(oe_n), .o_program_strobe_n(pgm_n),
    .o_programming_supply(vpp), .o_address_bus(abus), .o_data_bus(dbus),
    .o_data_bus_oe(doe), .i_data_bus(dret));
  uvp_eprom_model u_dev (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_pgm_n(pgm_n),
    .i_vpp(vpp), .i_addr(abus), .i_data(dbus), .i_data_oe(doe),
    .o_data(dret));
  // Hang guard, and a tally of program pulses
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      complete_run();
    end
  end
  always @(negedge pgm_n) npul++;
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(string nm, logic [16:0] exp, logic [16:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One command; a second start while busy must be ignored
  task automatic run(uvp_op_t op, uvp_addr_t ad, uvp_data_t wd);
    @(posedge i_mclk);
    i_op <= op;
    i_addr <= ad;
    i_wdata <= wd;
    i_start <= 1'b1;
    npul = 0;
    @(posedge i_mclk);
    i_start <= 1'b0;
    i_op <= (op == UVP_OP_READ) ? UVP_OP_PROG : UVP_OP_READ;
    repeat (3) @(posedge i_mclk);
    i_start <= 1'b1;
    @(posedge i_mclk);
    i_start <= 1'b0;
    while (o_done !== 1'b1) @(negedge i_mclk);
    @(negedge i_mclk);
    chk("busy", 17'h00000, {16'h0000, o_busy});
  endtask
  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    seed = lfsr(seed);
    run(UVP_OP_READ, {1'b0, seed}, 8'h00);
    chk("erased", 17'h000ff, {9'h000, o_rdata});
    a = {15'h7fff, seed[1:0]};
    d = seed[15:8];
    // First write, then its inverse, which can only clear bits
    for (int k = 0; k < 2; k++) begin
      st = (ref_mem.exists(a) ? ref_mem[a] : 8'hff) & d;
      fl = (st != d);
      ref_mem[a] = st;
      run(UVP_OP_PROG, a, d);
      chk("fail", {16'h0000, fl}, {16'h0000, o_fail});
      chk("pulses", fl ? 17'h0000a : 17'h00001, 17'(npul));
      if (fl) chk("fail addr", a, o_fail_addr);
      run(UVP_OP_READ, a, 8'h00);
      chk("readback", {9'h000, st}, {9'h000, o_rdata});
      d = ~d;
    end
    // Top block against the erased value at read levels
    fl = (st != 8'hff);
    run(UVP_OP_CHECK, 17'h1fffc, 8'hff);
    chk("check fail", {16'h0000, fl}, {16'h0000, o_fail});
    if (fl) chk("check addr", a, o_fail_addr);
    // Last address against its modelled content must pass and end the walk
    st = ref_mem.exists(17'h1ffff) ? ref_mem[17'h1ffff] : 8'hff;
    run(UVP_OP_CHECK, 17'h1ffff, st);
    chk("last check", 17'h00000, {16'h0000, o_fail});
    chk("last byte", {9'h000, st}, {9'h000, o_rdata});
    complete_run();
  end
endmodule
`default_nettype wire
